// ==== include/wb_ctrl_pkg.sv ====
// Constants and types for the writeback buffer control block.
// Assumes a single system clock with a synchronous active-high reset.
//
// Operation
// - On a replacement writeback the line-select output names the line to load into the buffer.
// - On a snoop writeback the line-select output flags a snoop hit to a line already buffered.
// - The writeback-kind output tells a replacement writeback from a snoop writeback.
// - A buffer load is the load strobe qualified by line-select and writeback-kind together.
// - The array-write strobe governs array writes.
// - A write-ordering configuration input selects strong or weak write ordering.
// - In strong ordering, writes leave for memory in the order the processor delivered them.
// - Line-select, kind and load pins carry the sector and line-ratio straps during reset.
// - Glitch-free outputs hold a valid level from the end of reset, with no spurious edges.
// - Memory strobe and select outputs are glitch free in both ordering modes.
package wb_ctrl_pkg;

  localparam logic KIND_REPLACE = 1'b0;
  localparam logic KIND_SNOOP = 1'b1;
  localparam logic STROBE_IDLE_N = 1'b1;
  localparam logic STROBE_ACT_N = 1'b0;
  localparam int WQ_DEPTH_DEF = 4;
  localparam int WQ_WIDTH_DEF = 32;

  typedef enum logic [1:0] {
    WB_IDLE,
    WB_LOAD,
    WB_DONE
  } wb_state_t;

endpackage : wb_ctrl_pkg

// ==== include/wq_if.sv ====
// Interface between the controller and its write-ordering queue.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface wq_if #(parameter int WIDTH = 32);
  logic push;
  logic [WIDTH-1:0] push_data;
  logic full;
  logic pop;
  logic [WIDTH-1:0] pop_data;
  logic empty;
  modport ctrl (output push, output push_data, input full, output pop, input pop_data,
    input empty);
  modport queue (input push, input push_data, output full, input pop, output pop_data,
    output empty);
endinterface : wq_if

// ==== rtl/write_order_queue.sv ====
// In-order posted-write queue.
// Assumes push is never raised while full nor pop while empty.
`timescale 1ns/100ps
module write_order_queue
  import wb_ctrl_pkg::*;
#(
  parameter int WIDTH = WQ_WIDTH_DEF,
  parameter int DEPTH = WQ_DEPTH_DEF
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Queue port.
  wq_if.queue q
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;

  // ==========================================================
  // Pointers
  always_comb begin
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    if (q.push) begin
      nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
    end
    if (q.pop) begin
      nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
    end
    if (q.push && !q.pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (q.pop && !q.push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (q.push) begin
      mem[wr_ff] <= q.push_data;
    end
  end

  assign q.pop_data = mem[rd_ff];
  assign q.full = (cnt_ff == (AW + 1)'(DEPTH));
  assign q.empty = (cnt_ff == '0);
endmodule : write_order_queue

// ==== rtl/writeback_buffer_control.sv ====
// Writeback buffer and array-write strobe control toward the cache data SRAMs.
// Assumes requests come from same-clock logic; strap inputs come from pins.
`timescale 1ns/100ps
module writeback_buffer_control
  import wb_ctrl_pkg::*;
#(
  parameter int WIDTH = WQ_WIDTH_DEF,
  parameter int DEPTH = WQ_DEPTH_DEF
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Strap values driven on the shared pins while reset is held.
  input wire logic sector_cfg_n,
  input wire logic line_ratio_cfg0,
  input wire logic line_ratio_cfg1,
  // Write-ordering configuration pin, sampled at reset release.
  input wire logic write_order_cfg_n,
  // Writeback requests.
  input wire logic wb_req,
  input wire logic wb_snoop,
  input wire logic wb_line,
  output logic wb_busy,
  // Array write requests.
  input wire logic arr_wr_req,
  // Posted writes from the processor side.
  input wire logic pw_valid,
  input wire logic [WIDTH-1:0] pw_data,
  output logic pw_ready,
  // Posted writes toward memory.
  output logic mw_valid,
  output logic [WIDTH-1:0] mw_data,
  input wire logic mw_ready,
  output logic strong_order,
  // SRAM side.
  output logic writeback_line_select,
  output logic writeback_kind,
  output logic wb_buffer_load_n,
  output logic array_write_n
);
  // Posted writes wait here in strong ordering mode only; weak mode never pushes.
  wq_if #(.WIDTH(WIDTH)) q ();

  write_order_queue #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_queue (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .q(q)
  );

  // ==========================================================
  // Pin synchronisers
  // The straps and the ordering pin come from outside the clock domain, so each one passes
  // two flops before the sequencer or the mode capture reads it.
  localparam int PIN_N = 4;
  localparam int PIN_ORDER = 3;
  localparam int PIN_SECTOR = 2;
  localparam int PIN_RATIO0 = 1;
  localparam int PIN_RATIO1 = 0;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_s1_ff, nxt_pin_s1;
  logic [PIN_N-1:0] pin_s2_ff, nxt_pin_s2;
  logic rst_d_ff, nxt_rst_d;

  assign pin_raw = {write_order_cfg_n, sector_cfg_n, line_ratio_cfg0, line_ratio_cfg1};

  always_comb begin
    nxt_pin_s1 = pin_raw;
    nxt_pin_s2 = pin_s1_ff;
    nxt_rst_d = sys_rst;
  end

  always_ff @(posedge sys_clk) begin
    pin_s1_ff <= nxt_pin_s1;
    pin_s2_ff <= nxt_pin_s2;
    rst_d_ff <= nxt_rst_d;
  end

  // ==========================================================
  // Ordering mode, caught at reset release
  // The mode is taken once, on the first edge after reset falls, and then held until the
  // next reset: switching it with writes in flight could let a later write overtake.
  // No reset on the mode flop: it only counts once reset has been released.
  logic strong_ff, nxt_strong;
  logic rst_fall;

  assign rst_fall = rst_d_ff && !sys_rst;

  always_comb begin
    nxt_strong = strong_ff;
    if (rst_fall) begin
      nxt_strong = pin_s2_ff[PIN_ORDER];
    end
  end

  always_ff @(posedge sys_clk) begin
    strong_ff <= nxt_strong;
  end

  // ==========================================================
  // Writeback sequencer
  // Select and kind are set one cycle ahead of the load strobe, so both qualifiers are
  // already steady on the edge at which the SRAMs load the buffer.
  wb_state_t st_ff, nxt_st;
  logic sel_ff, nxt_sel;
  logic kind_ff, nxt_kind;
  logic load_n_ff, nxt_load_n;
  logic arr_n_ff, nxt_arr_n;
  logic busy_ff, nxt_busy;

  always_comb begin
    nxt_st = st_ff;
    nxt_sel = sel_ff;
    nxt_kind = kind_ff;
    nxt_load_n = STROBE_IDLE_N;
    nxt_busy = busy_ff;
    nxt_arr_n = arr_wr_req ? STROBE_ACT_N : STROBE_IDLE_N;
    case (st_ff)
      WB_IDLE: begin
        if (wb_req) begin
          nxt_sel = wb_snoop ? 1'b1 : wb_line;
          nxt_kind = wb_snoop ? KIND_SNOOP : KIND_REPLACE;
          nxt_busy = 1'b1;
          nxt_st = WB_LOAD;
        end
      end
      WB_LOAD: begin
        nxt_load_n = STROBE_ACT_N;
        nxt_st = WB_DONE;
      end
      WB_DONE: begin
        nxt_busy = 1'b0;
        nxt_st = WB_IDLE;
      end
      default: begin
        nxt_st = WB_IDLE;
      end
    endcase
  end

  // Straps are driven while reset is held; all outputs then come from flops.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_ff <= WB_IDLE;
      busy_ff <= 1'b0;
      arr_n_ff <= STROBE_IDLE_N;
      sel_ff <= pin_s2_ff[PIN_SECTOR];
      kind_ff <= pin_s2_ff[PIN_RATIO0];
      load_n_ff <= pin_s2_ff[PIN_RATIO1];
    end else begin
      st_ff <= nxt_st;
      busy_ff <= nxt_busy;
      arr_n_ff <= nxt_arr_n;
      sel_ff <= nxt_sel;
      kind_ff <= nxt_kind;
      load_n_ff <= nxt_load_n;
    end
  end

  // ==========================================================
  // Write ordering path
  // Strong mode sends every posted write through the queue; weak mode hands it straight to
  // the memory register, which keeps the arrival order as well.
  logic mv_ff, nxt_mv, pr_ff, nxt_pr;
  logic [WIDTH-1:0] md_ff, nxt_md;
  logic take;

  assign take = pw_valid && pr_ff;
  assign q.push = take && strong_ff;
  assign q.push_data = pw_data;
  assign q.pop = strong_ff && !q.empty && (!mv_ff || mw_ready);

  always_comb begin
    nxt_mv = mv_ff;
    nxt_md = md_ff;
    // A word leaves the output register on the edge that sees mw_ready; a popped word may
    // refill it on that same edge, a bypassed word only when it was already empty.
    if (mv_ff && mw_ready) begin
      nxt_mv = 1'b0;
    end
    if (q.pop) begin
      nxt_mv = 1'b1;
      nxt_md = q.pop_data;
    end else if (!strong_ff && take) begin
      nxt_mv = 1'b1;
      nxt_md = pw_data;
    end
    // A registered ready must promise room in the next cycle, so in strong mode it never
    // follows a push, and in weak mode it only stands while the output register is empty.
    if (strong_ff) begin
      nxt_pr = !q.full && !q.push;
    end else begin
      nxt_pr = !nxt_mv;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mv_ff <= 1'b0;
      md_ff <= '0;
      pr_ff <= 1'b0;
    end else begin
      mv_ff <= nxt_mv;
      md_ff <= nxt_md;
      pr_ff <= nxt_pr;
    end
  end

  // ==========================================================
  // Outputs
  // Each output is a straight copy of a flop, so no decode can glitch a pin.

  assign writeback_line_select = sel_ff;
  assign writeback_kind = kind_ff;
  assign wb_buffer_load_n = load_n_ff;
  assign array_write_n = arr_n_ff;
  assign wb_busy = busy_ff;
  assign mw_valid = mv_ff;
  assign mw_data = md_ff;
  assign pw_ready = pr_ff;
  assign strong_order = strong_ff;
endmodule : writeback_buffer_control

// ==== bench/wb_sram_model.sv ====
// Behavioural model of the cache data SRAMs on the strobe side.
// Assumes the strobes are registered outputs of the controller.
`timescale 1ns/100ps
module wb_sram_model (
  // Clock, reset and strobes.
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic wb_buffer_load_n,
  input wire logic array_write_n
);
  int n_load = 0;
  int n_arr = 0;
  logic rst_q = 1'b1;
  // Each low cycle of a strobe is one load or one array write; the shared pins carry
  // straps through reset and for the first cycle after it, so those cycles are skipped.
  always @(posedge sys_clk) begin
    rst_q <= sys_rst;
    if (!sys_rst && !rst_q) begin
      if (wb_buffer_load_n === 1'b0) n_load++;
      if (array_write_n === 1'b0) n_arr++;
    end
  end
endmodule : wb_sram_model

// ==== bench/writeback_buffer_control_sva.sv ====
// Checker for the writeback buffer control ports.
// Assumes one clock and an active-high synchronous reset.
`timescale 1ns/100ps
module writeback_buffer_control_sva #(parameter int WIDTH = 32) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Configuration pin.
  input wire logic write_order_cfg_n,
  // Writeback and array write requests.
  input wire logic wb_req,
  input wire logic wb_snoop,
  input wire logic wb_line,
  input wire logic wb_busy,
  input wire logic arr_wr_req,
  // Posted writes.
  input wire logic pw_valid,
  input wire logic pw_ready,
  input wire logic mw_valid,
  input wire logic mw_ready,
  input wire logic strong_order,
  input wire logic [WIDTH-1:0] mw_data,
  // SRAM side.
  input wire logic writeback_line_select,
  input wire logic writeback_kind,
  input wire logic wb_buffer_load_n,
  input wire logic array_write_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire take = wb_req && !wb_busy;
  chk_load_timing: assert property (take |=> wb_busy ##1 !wb_buffer_load_n ##1 wb_buffer_load_n)
    else $error("load strobe timing wrong");
  chk_kind_value: assert property (take |=> writeback_kind == $past(wb_snoop))
    else $error("writeback kind wrong");
  chk_sel_replace: assert property (take && !wb_snoop |=> writeback_line_select == $past(wb_line))
    else $error("line select wrong");
  chk_sel_snoop: assert property (take && wb_snoop |=> writeback_line_select)
    else $error("snoop hit flag missing");
  chk_kind_steady: assert property (!take |=> $stable({writeback_kind, writeback_line_select}))
    else $error("select or kind moved");
  chk_arr_write: assert property (1 |=> array_write_n == !$past(arr_wr_req))
    else $error("array write strobe wrong");
  chk_mw_hold: assert property (mw_valid && !mw_ready |=> mw_valid && $stable(mw_data))
    else $error("memory write not held");
  chk_ready_drop: assert property (strong_order && pw_valid && pw_ready |=> !pw_ready)
    else $error("ready did not drop");
  chk_mode_fixed: assert property (!$past(sys_rst, 3) |-> $stable(strong_order))
    else $error("ordering mode changed");
  chk_mode_capture: assert property ($fell(sys_rst) |=>
    strong_order == $past(write_order_cfg_n, 2)) else $error("ordering mode not taken from pin");
endmodule : writeback_buffer_control_sva
bind writeback_buffer_control writeback_buffer_control_sva #(.WIDTH(WIDTH)) u_sva (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .write_order_cfg_n(write_order_cfg_n),
  .wb_req(wb_req),
  .wb_snoop(wb_snoop),
  .wb_line(wb_line),
  .wb_busy(wb_busy),
  .arr_wr_req(arr_wr_req),
  .pw_valid(pw_valid),
  .pw_ready(pw_ready),
  .mw_valid(mw_valid),
  .mw_ready(mw_ready),
  .strong_order(strong_order),
  .mw_data(mw_data),
  .writeback_line_select(writeback_line_select),
  .writeback_kind(writeback_kind),
  .wb_buffer_load_n(wb_buffer_load_n),
  .array_write_n(array_write_n)
);

// ==== bench/writeback_buffer_control_tb.sv ====
// Self-checking bench for the writeback buffer control block.
// Assumes the SRAM model and the bound checker are compiled first.
`timescale 1ns/100ps
`define CHK(nm, e, a) begin checks_done++; if ((e) !== (a)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, a); end end
module writeback_buffer_control_tb;
  import wb_ctrl_pkg::*;
  logic sys_clk = 0, sys_rst = 1, sector_cfg_n = 0, line_ratio_cfg0 = 0, line_ratio_cfg1 = 0;
  logic write_order_cfg_n = 1, wb_req = 0, wb_snoop = 0, wb_line = 0, arr_wr_req = 0;
  logic pw_valid = 0, mw_ready = 0, arr_en = 0, rst_q = 1;
  logic [31:0] pw_data = 0, mw_data, ed;
  logic wb_busy, pw_ready, mw_valid, strong_order, sel, kind, load_n, arr_n;
  logic [1:0] ew;
  logic [1:0] qw[$];
  logic [31:0] qd[$];
  int n_errors = 0, checks_done = 0, cyc = 0, n_arr_exp = 0, seed = 32'h323b_0e77;
  always #10 sys_clk = ~sys_clk;
  writeback_buffer_control DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .sector_cfg_n(sector_cfg_n), .line_ratio_cfg0(line_ratio_cfg0),
    .line_ratio_cfg1(line_ratio_cfg1), .write_order_cfg_n(write_order_cfg_n),
    .wb_req(wb_req), .wb_snoop(wb_snoop), .wb_line(wb_line), .wb_busy(wb_busy),
    .arr_wr_req(arr_wr_req), .pw_valid(pw_valid), .pw_data(pw_data), .pw_ready(pw_ready),
    .mw_valid(mw_valid), .mw_data(mw_data), .mw_ready(mw_ready), .strong_order(strong_order),
    .writeback_line_select(sel), .writeback_kind(kind), .wb_buffer_load_n(load_n),
    .array_write_n(arr_n));
  wb_sram_model u_sram (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_buffer_load_n(load_n),
    .array_write_n(arr_n));
  // ==========================================================
  // Stimulus tasks
  task automatic rst(input logic cfg);
    @(posedge sys_clk) #1 sys_rst = 1;
    write_order_cfg_n = cfg;
    {sector_cfg_n, line_ratio_cfg0, line_ratio_cfg1} = 3'($random(seed));
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("straps", {sector_cfg_n, line_ratio_cfg0, line_ratio_cfg1}, {sel, kind, load_n})
    @(posedge sys_clk) #1 sys_rst = 0;
    repeat (4) @(posedge sys_clk);
    #1 `CHK("mode", cfg, strong_order)
  endtask : rst
  task automatic wb(input logic s, input logic l);
    do @(negedge sys_clk); while (wb_busy !== 1'b0);
    @(posedge sys_clk) #1 {wb_req, wb_snoop, wb_line} = {1'b1, s, l};
    qw.push_back({s ? 1'b1 : l, s});
    @(posedge sys_clk) #1 wb_req = 0;
  endtask : wb
  task automatic pw(input logic [31:0] d);
    {pw_valid, pw_data} = {1'b1, d};
    qd.push_back(d);
    do @(negedge sys_clk); while (pw_ready !== 1'b1);
    @(posedge sys_clk) #1;
  endtask : pw
  task automatic phase(input logic cfg);
    rst(cfg);
    for (int i = 0; i < 8; i++) wb(i[0], i[1]);
    arr_en = 1;
    repeat (40) @(posedge sys_clk);
    #1 arr_en = 0;
    for (int i = 0; i < 10; i++) pw($random(seed));
    pw_valid = 0;
    repeat (40) @(posedge sys_clk);
    `CHK("loads", 8, u_sram.n_load)
    `CHK("arr", n_arr_exp, u_sram.n_arr)
    `CHK("drain", 0, qd.size() + qw.size())
    $display("Phase with ordering pin %0d done", cfg);
    u_sram.n_load = 0;
  endtask : phase
  // ==========================================================
  // Monitors and random drivers
  always @(posedge sys_clk) begin
    rst_q <= sys_rst;
    if (!sys_rst && !rst_q && load_n === 1'b0) begin
      ew = qw.pop_front();
      `CHK("load", ew, {sel, kind})
    end
    if (!sys_rst && mw_valid === 1'b1 && mw_ready === 1'b1) begin
      ed = qd.pop_front();
      `CHK("mw", ed, mw_data)
    end
    if (arr_wr_req === 1'b1) n_arr_exp++;
    cyc++;
    if (cyc > 5000) begin
      n_errors++;
      report_and_stop();
    end
    #1 mw_ready = $random(seed);
    arr_wr_req = arr_en & $random(seed);
  end
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  initial begin
    phase(1'b1);
    phase(1'b0);
    report_and_stop();
  end
endmodule : writeback_buffer_control_tb
